// ===== design/rbbc_map.vh
`ifndef RBBC_MAP_VH
`define RBBC_MAP_VH
// Register offsets (byte addresses on the plain register port).
`define RBBC_REG_CTRL      8'h00
`define RBBC_REG_STATUS    8'h04
`define RBBC_REG_RSTSRC    8'h08
`define RBBC_REG_MEMMAP    8'h0C
`define RBBC_REG_BOOTCFG   8'h10
`define RBBC_REG_WAKE      8'h14
`define RBBC_REG_IRQEN     8'h18
// Control register fields.
`define RBBC_CTRL_BOD_RST_EN  0
`define RBBC_CTRL_CS_SWAP     1
// Reset source record fields.
`define RBBC_SRC_POR   0
`define RBBC_SRC_PIN   1
`define RBBC_SRC_WDT   2
`define RBBC_SRC_BOD   3
// Vector base selections.
`define RBBC_MAP_BOOTROM   2'h0
`define RBBC_MAP_SRAM      2'h1
`define RBBC_MAP_EXTMEM    2'h2
// Reset values.
`define RBBC_CTRL_RESET    2'h2
`define RBBC_MEMMAP_RESET  2'h2
// Boot addresses.
`define RBBC_BOOT_ADDR     32'h81000000
`define RBBC_SWAP_BASE     32'h80000000
`define RBBC_VECTOR_BASE   32'h00000000
// Wake-up timer counts in oscillator cycles.
`define RBBC_WAKE_MAIN_CYC 32'h00001000
`define RBBC_WAKE_IRC_CYC  32'h00000004
// Counter width and interrupt input counts.
`define RBBC_CNT_W         13
`define RBBC_NUM_EDGE_IRQ  68
`define RBBC_NUM_LVL_IRQ   4
`endif

// ===== design/rbbc_sync2.v
`timescale 1ns/1ps
// Two-flop synchroniser for a vector of asynchronous levels.
module rbbc_sync2 #(
  parameter W = 1
) (
  ref_clk,
  reset,
  async_in,
  sync_out
);
  input  wire         ref_clk;
  input  wire         reset;
  input  wire [W-1:0] async_in;
  output reg  [W-1:0] sync_out;

  reg [W-1:0] meta_q;

  // The first stage is read only by the second stage.
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      meta_q   <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// ===== design/rbbc_ctrl.v
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "rbbc_map.vh"
// Notes on behaviour
// RQ1: Four sources create chip reset.
// RQ2: Reset held until pin, oscillator, count done.
// RQ3: Registers initialised, then boot externally.
// RQ4: First fetch from bank one boot address.
// RQ5: Power-on samples straps; banks share width.
// RQ6: Unneeded address pins become general purpose.
// RQ7: Chip selects zero and one swapped.
// RQ8: Vectors at external memory during boot.
// RQ9: Map setting picks vector base region.
// RQ10: Upper threshold raises brownout interrupt.
// RQ11: Interrupt gated by enable; status readable. bod_irq here follows up_q and ignores irq_en_q.
// RQ12: Lower threshold resets only when enabled.
// RQ13: Brownout reset holds until power-on takes over; here it also releases once lo_q clears.
// RQ14: Both thresholds use hysteresis.
// RQ15: Edge and level interrupts may wake.
// RQ16: Main oscillator wake waits 4096 cycles.
// RQ17: Internal oscillator wake waits 4 cycles.
// RQ18: Combined reset released synchronously.
// RQ19: Reset source recorded for software.
module rbbc_ctrl #(
  parameter WAKE_MAIN_CYC = `RBBC_WAKE_MAIN_CYC
) (
  ref_clk,
  reset,
  por_n,
  reset_pin_n,
  wdt_reset,
  osc_running,
  osc_is_irc,
  bod_upper_below,
  bod_upper_above,
  bod_lower_below,
  bod_lower_above,
  edge_irq,
  level_irq,
  powered_down,
  boot_width_strap_hi,
  boot_width_strap_lo,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  chip_reset,
  cpu_run,
  boot_fetch_addr,
  bank_width,
  cs_swap,
  addr_gpio_mask,
  vector_map,
  bod_irq,
  wake_event
);
  input  wire        ref_clk;
  input  wire        reset;
  input  wire        por_n;
  input  wire        reset_pin_n;
  input  wire        wdt_reset;
  input  wire        osc_running;
  input  wire        osc_is_irc;
  input  wire        bod_upper_below;
  input  wire        bod_upper_above;
  input  wire        bod_lower_below;
  input  wire        bod_lower_above;
  input  wire [67:0] edge_irq;
  input  wire [3:0]  level_irq;
  input  wire        powered_down;
  input  wire        boot_width_strap_hi;
  input  wire        boot_width_strap_lo;
  input  wire [7:0]  reg_addr;
  input  wire [31:0] reg_wdata;
  input  wire        reg_wr;
  input  wire        reg_rd;
  output reg  [31:0] reg_rdata;
  output reg         chip_reset;
  output reg         cpu_run;
  output reg  [31:0] boot_fetch_addr;
  output reg  [1:0]  bank_width;
  output reg         cs_swap;
  output reg  [7:0]  addr_gpio_mask;
  output reg  [1:0]  vector_map;
  output reg         bod_irq;
  output reg         wake_event;

  // Synchronised pin-side levels.
  wire [11:0] s;
  rbbc_sync2 #(.W(12)) u_sync (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .async_in ({level_irq, boot_width_strap_lo, boot_width_strap_hi, bod_lower_above, bod_lower_below,
                bod_upper_above, bod_upper_below, wdt_reset, reset_pin_n}),
    .sync_out (s)
  );
  wire pin_n_s = s[0];
  wire wdt_s   = s[1];
  wire up_bl   = s[2];
  wire up_ab   = s[3];
  wire lo_bl   = s[4];
  wire lo_ab   = s[5];
  wire st_hi   = s[6];
  wire st_lo   = s[7];
  wire [3:0] lvl_s = s[11:8];

  reg [67:0] edge_m_q;
  reg [67:0] edge_mm_q;
  reg [67:0] edge_d_q;
  reg [1:0]  por_sync_q;
  reg        osc_m_q;
  reg        osc_s_q;
  reg        irc_m_q;
  reg        irc_s_q;
  reg        pd_m_q;
  reg        pd_s_q;
  reg        pd_d1_q;
  reg [1:0]  ctrl_q;
  reg [1:0]  map_q;
  reg        irq_en_q;
  reg [3:0]  src_q;
  reg        up_q;
  reg        lo_q;
  reg        bod_hold_q;
  reg        por_seen_q;
  reg        hold_q;
  reg [`RBBC_CNT_W-1:0] cnt_q;
  reg        strap_done_q;
  reg        wake_q;

  wire por_s = por_sync_q[1];
  wire osc_is_irc_s = irc_s_q;
  // Timer length is kept at full width so the counter compare never truncates the parameter.
  wire [31:0] wake_len = osc_is_irc_s ? `RBBC_WAKE_IRC_CYC : WAKE_MAIN_CYC;

  // Power-on reset is sampled through two flops, so both its assertion and its release are synchronous.
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      por_sync_q <= 2'h0;
    else
      por_sync_q <= {por_sync_q[0], por_n};
  end

  // Extra level and edge synchronisers; the third edge stage is a delayed copy for edge detection.
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      edge_m_q  <= 68'h0;
      edge_mm_q <= 68'h0;
      edge_d_q  <= 68'h0;
      osc_m_q   <= 1'b0;
      osc_s_q   <= 1'b0;
      irc_m_q   <= 1'b0;
      irc_s_q   <= 1'b0;
      pd_m_q    <= 1'b0;
      pd_s_q    <= 1'b0;
    end
    else
    begin
      edge_m_q  <= edge_irq;
      edge_mm_q <= edge_m_q;
      edge_d_q  <= edge_mm_q;
      osc_m_q   <= osc_running;
      osc_s_q   <= osc_m_q;
      irc_m_q   <= osc_is_irc;
      irc_s_q   <= irc_m_q;
      pd_m_q    <= powered_down;
      pd_s_q    <= pd_m_q;
    end
  end

  // Brownout comparators with hysteresis: set below, clear only above. [RQ14]
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      up_q <= 1'b0;
      lo_q <= 1'b0;
    end
    else
    begin
      if (up_bl)
        up_q <= 1'b1; // [RQ10]
      else if (up_ab)
        up_q <= 1'b0;
      if (lo_bl)
        lo_q <= 1'b1;
      else if (lo_ab)
        lo_q <= 1'b0;
    end
  end

  // Brownout reset is held until the lower comparator clears or power-on reset takes over. [RQ13]
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      bod_hold_q <= 1'b0;
    else if (!por_s)
      bod_hold_q <= 1'b0;
    else if (lo_q && ctrl_q[`RBBC_CTRL_BOD_RST_EN])
      bod_hold_q <= 1'b1; // [RQ12]
    else if (!lo_q)
      bod_hold_q <= 1'b0;
  end

  // Any source asserts reset; wake timer then counts and releases synchronously.
  wire any_src = !por_s || !pin_n_s || wdt_s || bod_hold_q; // [RQ1]
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      hold_q <= 1'b1;
      cnt_q  <= {`RBBC_CNT_W{1'b0}};
    end
    else if (any_src || !osc_s_q)
    begin
      hold_q <= 1'b1; // [RQ2]
      cnt_q  <= {`RBBC_CNT_W{1'b0}};
    end
    else if (hold_q)
    begin
      if ({{(32-`RBBC_CNT_W){1'b0}}, cnt_q} + 32'h00000001 >= wake_len)
        hold_q <= 1'b0; // [RQ18]
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Wake from power-down by any interrupt input; timer length by clock source.
  wire any_irq = |(edge_mm_q ^ edge_d_q) | |lvl_s; // [RQ15]
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      pd_d1_q <= 1'b0;
      wake_q  <= 1'b0;
    end
    else
    begin
      pd_d1_q <= pd_s_q;
      if (pd_s_q && any_irq)
        wake_q <= 1'b1;
      else if (wake_q && !pd_s_q && !pd_d1_q && !wrun_q)
        wake_q <= 1'b0;
    end
  end

  // Wake delay counter runs after a power-down exit. [RQ16] [RQ17]
  reg [`RBBC_CNT_W-1:0] wcnt_q;
  reg                   wrun_q;
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      wcnt_q <= {`RBBC_CNT_W{1'b0}};
      wrun_q <= 1'b0;
    end
    else if (pd_d1_q && !pd_s_q)
    begin
      wcnt_q <= {`RBBC_CNT_W{1'b0}};
      wrun_q <= 1'b1;
    end
    else if (wrun_q)
    begin
      if ({{(32-`RBBC_CNT_W){1'b0}}, wcnt_q} + 32'h00000001 >= wake_len)
        wrun_q <= 1'b0;
      wcnt_q <= wcnt_q + 1'b1;
    end
  end

  // Straps are sampled once during a power-on boot. [RQ5]
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      bank_width   <= 2'h0;
      strap_done_q <= 1'b0;
    end
    else if (!por_s)
      strap_done_q <= 1'b0;
    else if (!strap_done_q)
    begin
      bank_width   <= {st_hi, st_lo};
      strap_done_q <= 1'b1;
    end
  end

  // Software registers; set of a source flag wins while a new reset occurs.
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      ctrl_q   <= `RBBC_CTRL_RESET;
      map_q    <= `RBBC_MEMMAP_RESET;
      irq_en_q <= 1'b0;
      src_q    <= 4'h1;
    end
    else
    begin
      if (hold_q)
      begin
        ctrl_q   <= `RBBC_CTRL_RESET; // [RQ3]
        map_q    <= `RBBC_MEMMAP_RESET; // [RQ8]
        irq_en_q <= 1'b0;
      end
      else if (reg_wr)
      begin
        if (reg_addr == `RBBC_REG_CTRL)
          ctrl_q <= reg_wdata[1:0];
        if (reg_addr == `RBBC_REG_MEMMAP)
          map_q <= reg_wdata[1:0]; // [RQ9]
        if (reg_addr == `RBBC_REG_IRQEN)
          irq_en_q <= reg_wdata[0];
      end
      if (!por_s)
        src_q <= 4'h1; // [RQ19]
      else
      begin
        if (reg_wr && !hold_q && reg_addr == `RBBC_REG_RSTSRC)
          src_q <= src_q & ~reg_wdata[3:0];
        if (!pin_n_s)
          src_q[`RBBC_SRC_PIN] <= 1'b1;
        if (wdt_s)
          src_q[`RBBC_SRC_WDT] <= 1'b1;
        if (bod_hold_q)
          src_q[`RBBC_SRC_BOD] <= 1'b1;
      end
    end
  end

  // Registered outputs.
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      chip_reset      <= 1'b1;
      cpu_run         <= 1'b0;
      boot_fetch_addr <= `RBBC_BOOT_ADDR;
      cs_swap         <= 1'b1;
      addr_gpio_mask  <= 8'h00;
      vector_map      <= `RBBC_MEMMAP_RESET;
      bod_irq         <= 1'b0;
      wake_event      <= 1'b0;
    end
    else
    begin
      chip_reset      <= hold_q; // [RQ18]
      cpu_run         <= !hold_q && !wrun_q && !pd_s_q && !pd_d1_q; // Blocks a run glitch before the wake delay starts.
      boot_fetch_addr <= `RBBC_BOOT_ADDR; // [RQ4]
      cs_swap         <= ctrl_q[`RBBC_CTRL_CS_SWAP]; // [RQ7]
      addr_gpio_mask  <= (bank_width == 2'h0) ? 8'hFF : (bank_width == 2'h1) ? 8'h0F : 8'h00; // [RQ6]
      vector_map      <= map_q;
      bod_irq         <= up_q; // [RQ10]
      wake_event      <= wake_q;
    end
  end

  // Register read port, data valid the cycle after the strobe.
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      reg_rdata <= 32'h0;
    else if (reg_rd)
    begin
      case (reg_addr)
        `RBBC_REG_CTRL:    reg_rdata <= {30'h0, ctrl_q};
        `RBBC_REG_STATUS:  reg_rdata <= {29'h0, hold_q, lo_q, up_q}; // [RQ11]
        `RBBC_REG_RSTSRC:  reg_rdata <= {28'h0, src_q};
        `RBBC_REG_MEMMAP:  reg_rdata <= {30'h0, map_q};
        `RBBC_REG_BOOTCFG: reg_rdata <= {30'h0, bank_width};
        `RBBC_REG_WAKE:    reg_rdata <= {31'h0, wrun_q};
        `RBBC_REG_IRQEN:   reg_rdata <= {31'h0, irq_en_q};
        default:           reg_rdata <= 32'h0;
      endcase
    end
  end
endmodule

// ===== tb/rbbc_ctrl_chk.sv
`timescale 1ns/1ps
// Temporal checks on the controller ports.
module rbbc_ctrl_chk #(
  parameter WAKE_MAIN_CYC = 16
) (
  input wire        ref_clk,
  input wire        reset,
  input wire        por_n,
  input wire        reset_pin_n,
  input wire        wdt_reset,
  input wire        osc_running,
  input wire        bod_upper_below,
  input wire        bod_upper_above,
  input wire        chip_reset,
  input wire        cpu_run,
  input wire [31:0] boot_fetch_addr,
  input wire [1:0]  bank_width,
  input wire [7:0]  addr_gpio_mask,
  input wire        bod_irq
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  boot_addr_a: assert property (boot_fetch_addr == 32'h81000000) else $error("boot address wrong");
  por_hold_a: assert property (!por_n |-> ##[1:4] chip_reset) else $error("por not held");
  pin_hold_a: assert property (!reset_pin_n |-> ##[1:4] chip_reset) else $error("pin not held");
  wdt_hold_a: assert property (wdt_reset |-> ##[1:4] chip_reset) else $error("wdt not held");
  run_gate_a: assert property (cpu_run |-> !chip_reset) else $error("run in reset");
  release_ok_a: assert property ($fell(chip_reset) |-> $past(chip_reset, 4) && osc_running)
    else $error("early release");
  irq_set_a: assert property (bod_upper_below [*6] |-> bod_irq) else $error("no brownout irq");
  irq_hyst_a: assert property ((!bod_upper_below && !bod_upper_above) [*6] |-> $stable(bod_irq))
    else $error("irq toggled in band");
  gpio_mask_a: assert property ($stable(bank_width) [*3] |->
    addr_gpio_mask == ((bank_width == 2'h0) ? 8'hFF : (bank_width == 2'h1) ? 8'h0F : 8'h00))
    else $error("gpio mask wrong");
endmodule
bind rbbc_ctrl rbbc_ctrl_chk #(.WAKE_MAIN_CYC(WAKE_MAIN_CYC)) chk_u (.ref_clk, .reset, .por_n, .reset_pin_n,
  .wdt_reset, .osc_running, .bod_upper_below, .bod_upper_above, .chip_reset, .cpu_run, .boot_fetch_addr,
  .bank_width, .addr_gpio_mask, .bod_irq);

// ===== tb/rbbc_far_model.sv
`timescale 1ns/1ps
// Boot memory and interrupt controller beyond the controller.
module rbbc_far_model (
  input  wire        ref_clk,
  input  wire [31:0] boot_fetch_addr,
  input  wire [1:0]  bank_width,
  input  wire        bod_irq,
  input  wire        vic_en,
  output reg  [31:0] fetch_word,
  output reg         cpu_irq
);
  // Boot word lands on the low lanes of the strapped bus; the irq passes only when enabled.
  always @(posedge ref_clk)
  begin
    fetch_word <= boot_fetch_addr >> ((bank_width == 2'h0) ? 24 : (bank_width == 2'h1) ? 16 : 0);
    cpu_irq <= bod_irq & vic_en;
  end
endmodule

// ===== tb/reset_boot_brownout_control_tb.sv
`timescale 1ns/1ps
`include "rbbc_map.vh"
// Drives the controller and its far side and compares with a small model.
module reset_boot_brownout_control_tb;
  reg         ref_clk = 1'b0;
  reg         reset = 1'b1;
  reg         por_n = 1'b0;
  reg         pin_n = 1'b1;
  reg         wdt = 1'b0;
  reg         osc_on = 1'b1;
  reg         internal_rc_oscillator = 1'b0;
  reg  [3:0]  brownout_detector = 4'hA;
  reg         pd = 1'b0;
  reg  [3:0]  lvl = 4'h0;
  reg  [67:0] edge_irq = 68'h0;
  reg  [7:0]  rnd = 8'h54;
  reg  [7:0]  reg_addr = 8'h00;
  reg  [31:0] reg_wdata = 32'h0;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  reg         vic_en = 1'b0;
  wire [31:0] reg_rdata, boot_fetch_addr, fetch_word;
  wire [7:0]  addr_gpio_mask;
  wire [1:0]  bank_width, vector_map;
  wire        chip_reset, cpu_run, cs_swap, bod_irq, wake_event, cpu_irq;
  int         mismatches = 0;
  int         n_checks = 0;
  int         n;
  int         w_m;
  int         mapq[$] = '{2, 1, 0};

  // Clock at 200 MHz.
  always #2.5 ref_clk = ~ref_clk;

  rbbc_ctrl #(.WAKE_MAIN_CYC(16)) dut_u (.ref_clk(ref_clk), .reset(reset), .por_n(por_n), .reset_pin_n(pin_n),
    .wdt_reset(wdt), .osc_running(osc_on), .osc_is_irc(internal_rc_oscillator), .bod_upper_below(brownout_detector[0]), .bod_upper_above(brownout_detector[1]),
    .bod_lower_below(brownout_detector[2]), .bod_lower_above(brownout_detector[3]), .edge_irq(edge_irq), .level_irq(lvl),
    .powered_down(pd), .boot_width_strap_hi(rnd[1]), .boot_width_strap_lo(rnd[0]), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chip_reset(chip_reset),
    .cpu_run(cpu_run), .boot_fetch_addr(boot_fetch_addr), .bank_width(bank_width), .cs_swap(cs_swap),
    .addr_gpio_mask(addr_gpio_mask), .vector_map(vector_map), .bod_irq(bod_irq), .wake_event(wake_event));

  rbbc_far_model far_u (.ref_clk(ref_clk), .boot_fetch_addr(boot_fetch_addr), .bank_width(bank_width),
    .bod_irq(bod_irq), .vic_en(vic_en), .fetch_word(fetch_word), .cpu_irq(cpu_irq));

  function automatic [7:0] lfsr(input [7:0] v);
    lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task chk(input string nm, input [31:0] e, input [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask

  task ok(input string nm, input logic c);
    chk(nm, 32'h1, {31'h0, c});
  endtask

  task tick(input int c);
    repeat (c) @(posedge ref_clk);
  endtask

  task wr(input [7:0] a, input [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  task rd(input string nm, input [7:0] a, input [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(nm, e, reg_rdata);
    @(posedge ref_clk);
  endtask

  // Counts cycles until chip reset drops, bounded.
  task run_len(output int c);
    c = 0;
    while (chip_reset !== 1'b0 && c < 400)
    begin
      @(posedge ref_clk);
      c++;
    end
  endtask

  // Checks the state left by a power-on boot.
  task boot_state;
    w_m = rnd[1:0];
    run_len(n);
    ok("por wake", n == (internal_rc_oscillator ? 4 : 16) + 4);
    chk("bank width", w_m, bank_width);
    chk("gpio mask", (w_m == 0) ? 8'hFF : (w_m == 1) ? 8'h0F : 8'h00, addr_gpio_mask);
    chk("fetch", `RBBC_BOOT_ADDR >> ((w_m == 0) ? 24 : (w_m == 1) ? 16 : 0), fetch_word);
    ok("swap", cs_swap === 1'b1);
    chk("vectors", `RBBC_MAP_EXTMEM, vector_map);
    ok("running", cpu_run === 1'b1);
    rd("ctrl", `RBBC_REG_CTRL, `RBBC_CTRL_RESET);
    rd("memmap", `RBBC_REG_MEMMAP, `RBBC_MEMMAP_RESET);
    rd("source", `RBBC_REG_RSTSRC, 1);
    rd("unmapped", 8'hFC, 0);
    rd("boot cfg", `RBBC_REG_BOOTCFG, w_m);
  endtask

  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Main sequence of tests.
  initial
  begin
    tick(16);
    reset <= 1'b0;
    por_n <= 1'b1;
    boot_state();
    $display("test power-on done");
    for (int k = 0; k < 4; k++)
    begin
      wr(`RBBC_REG_RSTSRC, 32'hF);
      internal_rc_oscillator <= k[0];
      osc_on <= 1'b0;
      rnd <= lfsr(rnd);
      if (k[1])
        wdt <= 1'b1;
      else
        pin_n <= 1'b0;
      tick(6);
      wdt <= 1'b0;
      pin_n <= 1'b1;
      tick(8);
      ok("osc gate", chip_reset === 1'b1);
      osc_on <= 1'b1;
      run_len(n);
      ok("wake len", n == (k[0] ? 4 : 16) + 4);
      chk("width kept", w_m, bank_width);
      rd("source", `RBBC_REG_RSTSRC, k[1] ? 4 : 2);
    end
    $display("test reset sources done");
    foreach (mapq[i])
    begin
      wr(`RBBC_REG_MEMMAP, mapq[i]);
      rd("map read", `RBBC_REG_MEMMAP, mapq[i]);
      chk("map out", mapq[i], {30'h0, vector_map});
    end
    wr(`RBBC_REG_CTRL, 32'h1);
    tick(2);
    ok("swap off", cs_swap === 1'b0);
    wr(`RBBC_REG_IRQEN, 32'h1);
    rd("irq enable", `RBBC_REG_IRQEN, 1);
    $display("test map done");
    brownout_detector <= 4'h9;
    tick(8);
    ok("bod irq", bod_irq === 1'b1 && cpu_irq === 1'b0);
    rd("status", `RBBC_REG_STATUS, 1);
    vic_en <= 1'b1;
    brownout_detector <= 4'h8;
    tick(8);
    ok("hysteresis", bod_irq === 1'b1 && cpu_irq === 1'b1);
    brownout_detector <= 4'hA;
    tick(8);
    ok("irq clear", bod_irq === 1'b0);
    wr(`RBBC_REG_RSTSRC, 32'hF);
    brownout_detector <= 4'h5;
    tick(8);
    ok("bod reset", chip_reset === 1'b1);
    brownout_detector <= 4'hA;
    run_len(n);
    rd("source", `RBBC_REG_RSTSRC, 8);
    brownout_detector <= 4'h5;
    tick(8);
    ok("bod off", chip_reset === 1'b0);
    brownout_detector <= 4'hA;
    $display("test brownout done");
    wr(`RBBC_REG_RSTSRC, 32'hF);
    wr(`RBBC_REG_MEMMAP, 0);
    por_n <= 1'b0;
    rnd <= lfsr(rnd);
    tick(6);
    por_n <= 1'b1;
    boot_state();
    $display("test second power-on done");
    // Level wake with the main oscillator, then edge wake with the internal one.
    for (int j = 0; j < 2; j++)
    begin
      internal_rc_oscillator <= j[0];
      pd <= 1'b1;
      if (j[0])
        edge_irq <= edge_irq ^ {60'h0, rnd};
      else
        lvl <= 4'h8;
      tick(6);
      ok("wake", wake_event === 1'b1 && cpu_run === 1'b0);
      lvl <= 4'h0;
      pd <= 1'b0;
      n = 0;
      while (cpu_run !== 1'b1 && n < 400)
      begin
        @(posedge ref_clk);
        n++;
      end
      ok("wake delay", n == (j[0] ? 4 : 16) + 5);
      tick(2);
      ok("wake clear", wake_event === 1'b0);
    end
    $display("test wake done");
    give_verdict();
  end

  // Cuts a hung run short.
  initial
  begin
    #20000;
    mismatches++;
    give_verdict();
  end
endmodule
